/* verilog/stats_pkg.sv */
// Shared constants, types and helpers for the Ethernet statistics block
package stats_pkg;
  localparam int NSLOT = 47;                        // 32-bit words in a snapshot
  localparam logic [7:0] SNAP_BYTES = 8'hbc;        // Snapshot length in bytes
  localparam logic [7:0] REQ_TYPE = 8'hc0;          // Vendor, device-to-host
  localparam logic [7:0] REQ_CODE = 8'ha2;          // Get statistics
  // Slot indices; byte offset in the data stage is four times the index
  localparam int SL_RX_FCS = 0, SL_RX_ALIGN = 1, SL_RX_FRAG = 2, SL_RX_JAB = 3;
  localparam int SL_RX_UNDER = 4, SL_RX_OVER = 5, SL_RX_DROP = 6;
  localparam int SL_RX_BYTES = 7, SL_RX_FRAMES = 10, SL_RX_PAUSE = 13;
  localparam int SL_RX_BIN = 14, SL_RX_LPI_TR = 21, SL_RX_LPI_TM = 22;
  localparam int SL_TX_FCS = 23, SL_TX_DEFER = 24, SL_TX_CARR = 25, SL_TX_BADB = 26;
  localparam int SL_TX_SCOL = 27, SL_TX_MCOL = 28, SL_TX_XCOL = 29, SL_TX_LCOL = 30;
  localparam int SL_TX_BYTES = 31, SL_TX_FRAMES = 34, SL_TX_PAUSE = 37;
  localparam int SL_TX_BIN = 38, SL_TX_LPI_TR = 45, SL_TX_LPI_TM = 46;
  // APB register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000, A_MAXSZ = 12'h004;
  localparam logic [11:0] A_VLAN = 12'h008, A_STAT = 12'h00c;
  // Control register bit positions
  localparam int B_VLAN_ALLOW = 0, B_STORE_BAD = 1, B_LITE_RST = 2;
  // Reset values and frame lengths
  localparam logic [13:0] MAXSZ_RST = 14'h05ee;     // Max frame size after reset
  localparam logic [15:0] VLAN_RST = 16'h8100;      // Extra ethertype after reset
  localparam logic [15:0] VLAN_STD = 16'h8100;      // Standard tag ethertype
  localparam logic [13:0] MIN_LEN = 14'h0040;       // Shortest legal frame
  localparam logic [13:0] TAG_LEN = 14'h0004;       // Bytes per VLAN tag
  // Low-power-idle time unit
  localparam int CLK_NS = 20;
  localparam int LPI_UNIT_NS = 1000;
  localparam logic [5:0] LPI_UNIT_CYC = 6'(LPI_UNIT_NS / CLK_NS);
  // Snapshot sender states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_FETCH = 4'h2, ST_PRESENT = 4'h4, ST_HOLD = 4'h8
  } snd_state_t;
  // Byte counts, bad bytes and LPI words are full 32-bit counters
  function automatic logic [31:0] slot_mask(input int s);
    if ((s >= SL_RX_BYTES && s < SL_RX_FRAMES) || (s >= SL_TX_BYTES && s < SL_TX_FRAMES)
        || s == SL_TX_BADB || s == SL_RX_LPI_TR || s == SL_RX_LPI_TM
        || s == SL_TX_LPI_TR || s == SL_TX_LPI_TM) return 32'hffffffff;
    return 32'h000fffff;
  endfunction
  // Length bin 0..6 for 64, 65-127, ..., 1024-1518, above 1518
  function automatic int len_bin(input logic [13:0] n);
    if (n <= 14'h0040) return 0;
    if (n <= 14'h007f) return 1;
    if (n <= 14'h00ff) return 2;
    if (n <= 14'h01ff) return 3;
    if (n <= 14'h03ff) return 4;
    if (n <= 14'h05ee) return 5;
    return 6;
  endfunction
  // Cast code 3 is folded into multicast
  function automatic int cast_idx(input logic [1:0] c);
    return (c == 2'h3) ? 2 : int'(c);
  endfunction
endpackage

/* verilog/stats_snap_mem.sv */
// Snapshot store: parallel load of all counters, registered word read
`timescale 1ns/1ns
`default_nettype none
module stats_snap_mem
  import stats_pkg::*;
(
  input  wire logic                  i_ref_clk,   // System clock
  input  wire logic                  i_load,      // Capture all words
  input  wire logic [NSLOT*32-1:0]   i_load_data, // Counters, slot 0 lowest
  input  wire logic [5:0]            i_rd_addr,   // Word to read
  output logic      [31:0]           o_rd_data    // Read word, one cycle late
);
  logic [31:0] mem_r [NSLOT];                     // Frozen counter image

  // Whole image is written in one edge so every word is from the same instant
  always_ff @(posedge i_ref_clk) begin
    if (i_load) begin
      for (int k = 0; k < NSLOT; k++) mem_r[k] <= i_load_data[k*32 +: 32];
    end
  end

  // Out-of-range address reads zero rather than garbage
  always_ff @(posedge i_ref_clk) begin
    if (int'(i_rd_addr) < NSLOT) o_rd_data <= mem_r[i_rd_addr];
    else o_rd_data <= 32'h00000000;
  end
endmodule // stats_snap_mem
`default_nettype wire

/* verilog/ethernet_statistics_counters.sv */
// Ethernet RX/TX statistics counters with USB snapshot request and APB control
`timescale 1ns/1ns
`default_nettype none
module ethernet_statistics_counters
  import stats_pkg::*;
(
  input  wire logic        i_ref_clk,        // 50 MHz system clock
  input  wire logic        i_nrst,           // Async reset, active low
  input  wire logic [11:0] i_paddr,          // APB address
  input  wire logic        i_psel,           // APB select
  input  wire logic        i_penable,        // APB access phase
  input  wire logic        i_pwrite,         // APB write
  input  wire logic [31:0] i_pwdata,         // APB write data
  output logic      [31:0] o_prdata,         // APB read data
  output logic             o_pready,         // APB ready
  output logic             o_pslverr,        // APB unmapped address
  input  wire logic        i_rx_done,        // RX frame status pulse
  input  wire logic [13:0] i_rx_len,         // RX whole bytes received
  input  wire logic        i_rx_fcs_err,     // RX CRC mismatch
  input  wire logic        i_rx_sym_err,     // RX symbol error
  input  wire logic        i_rx_align_err,   // RX alignment error
  input  wire logic        i_rx_drop,        // RX discarded by fifo_controller
  input  wire logic [1:0]  i_rx_cast,        // 0 uni, 1 broad, 2 multi
  input  wire logic        i_rx_pause,       // RX pause frame
  input  wire logic [15:0] i_rx_type,        // Outer type field
  input  wire logic [15:0] i_rx_inner_type,  // Type after first tag
  input  wire logic        i_rx_lpi,         // RX in low power idle
  input  wire logic        i_tx_done,        // TX frame status pulse
  input  wire logic [13:0] i_tx_len,         // TX bytes sent
  input  wire logic        i_tx_fcs_err,     // TX FCS error
  input  wire logic        i_tx_defer_err,   // TX excess deferral
  input  wire logic        i_tx_carrier_err, // TX carrier error
  input  wire logic        i_tx_single_col,  // TX one collision
  input  wire logic        i_tx_multi_col,   // TX several collisions
  input  wire logic        i_tx_exc_col,     // TX excessive collisions
  input  wire logic        i_tx_late_col,    // TX late collision
  input  wire logic [1:0]  i_tx_cast,        // 0 uni, 1 broad, 2 multi
  input  wire logic        i_tx_pause,       // TX pause frame
  input  wire logic        i_tx_lpi,         // TX in low power idle
  input  wire logic        i_setup_valid,    // Setup packet pulse
  input  wire logic [7:0]  i_req_type,       // Setup request type
  input  wire logic [7:0]  i_req_code,       // Setup request code
  input  wire logic [15:0] i_req_value,      // Setup value
  input  wire logic [15:0] i_req_index,      // Setup index
  input  wire logic [15:0] i_req_length,     // Setup length
  output logic             o_req_ack,        // Request claimed pulse
  output logic      [7:0]  o_data,           // Data stage byte
  output logic             o_data_valid,     // Byte valid
  output logic             o_data_last,      // Last byte of data stage
  input  wire logic        i_data_ready      // Endpoint takes byte
);
  logic [31:0]   cnt_r [NSLOT];               // Live counters
  logic [31:0]   addv [NSLOT];                // Per-slot increment
  logic [NSLOT*32-1:0] snap_flat;             // Counters packed for capture
  logic [31:0]   rd_word;                     // Snapshot word read back
  logic          vlan_allow_r;                // vlan_size_allowance
  logic          store_bad_r;                 // rx_fifo_control store bad frames
  logic          lite_r;                      // lite_reset pulse
  logic [13:0]   max_size_r;                  // Maximum frame size
  logic [15:0]   vlan_ethertype_reg_r;                 // vlan_ethertype_reg
  logic          rx_lpi_q_r, tx_lpi_q_r;      // LPI level last cycle
  logic [5:0]    unit_cnt_r;                  // Microsecond prescaler
  logic          unit_tick;                   // One cycle per microsecond
  logic          tag1, tag2;                  // Single and stacked tag
  logic [13:0]   max_len;                     // Legal length incl. tags
  logic          rx_err, rx_short, rx_long;   // RX classification
  logic          rx_any_err, rx_count_ok;
  logic          tx_any_err;
  logic          setup_hit;                   // Statistics request seen
  snd_state_t    state_r;                     // Sender state
  logic [7:0]    idx_r;                       // Byte index in snapshot
  logic [7:0]    rem_r;                       // Bytes left to send
  logic          apb_acc;                     // APB access being answered

  // RX classification; length is whole bytes so trailing bits never count
  always_comb begin
    tag1 = (i_rx_type == VLAN_STD) || (i_rx_type == vlan_ethertype_reg_r);
    tag2 = tag1 && ((i_rx_inner_type == VLAN_STD) || (i_rx_inner_type == vlan_ethertype_reg_r));
    max_len = max_size_r;
    if (vlan_allow_r && tag1) max_len = max_len + TAG_LEN;
    if (vlan_allow_r && tag2) max_len = max_len + TAG_LEN;
    rx_err = i_rx_fcs_err | i_rx_sym_err;
    rx_short = i_rx_len < MIN_LEN;
    rx_long = i_rx_len > max_len;
    rx_any_err = rx_err | i_rx_align_err | rx_short | rx_long;
    // Good counters see delivered frames, plus bad ones when storing them
    rx_count_ok = !i_rx_drop && (!rx_any_err || store_bad_r);
    tx_any_err = i_tx_fcs_err | i_tx_defer_err | i_tx_carrier_err
                 | i_tx_exc_col | i_tx_late_col;
  end

  // Microsecond tick for LPI time counters
  assign unit_tick = (unit_cnt_r == LPI_UNIT_CYC - 6'h01);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) unit_cnt_r <= 6'h00;
    else if (unit_tick) unit_cnt_r <= 6'h00;
    else unit_cnt_r <= unit_cnt_r + 6'h01;
  end

  // LPI level history for transition counts
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_lpi_q_r <= 1'b0;
      tx_lpi_q_r <= 1'b0;
    end else begin
      rx_lpi_q_r <= i_rx_lpi;
      tx_lpi_q_r <= i_tx_lpi;
    end
  end

  // Increment for every slot from this cycle's events
  always_comb begin
    for (int k = 0; k < NSLOT; k++) addv[k] = 32'h00000000;
    if (i_rx_done) begin
      addv[SL_RX_FCS] = {31'h0, rx_err & !rx_short & !rx_long};
      addv[SL_RX_ALIGN] = {31'h0, i_rx_align_err};
      addv[SL_RX_FRAG] = {31'h0, rx_err & rx_short};
      addv[SL_RX_JAB] = {31'h0, rx_err & rx_long};
      addv[SL_RX_UNDER] = {31'h0, rx_short & !rx_err & !i_rx_align_err};
      addv[SL_RX_OVER] = {31'h0, rx_long & !rx_err & !i_rx_align_err};
      // Errored frames are already in their error counter above
      addv[SL_RX_DROP] = {31'h0, i_rx_drop & (!rx_any_err | store_bad_r)};
      if (rx_count_ok) begin
        addv[SL_RX_BYTES + cast_idx(i_rx_cast)] = {18'h0, i_rx_len};
        addv[SL_RX_FRAMES + cast_idx(i_rx_cast)] = 32'h00000001;
        addv[SL_RX_PAUSE] = {31'h0, i_rx_pause};
        addv[SL_RX_BIN + len_bin(i_rx_len)] = 32'h00000001;
      end
    end
    addv[SL_RX_LPI_TR] = {31'h0, i_rx_lpi & !rx_lpi_q_r};
    addv[SL_RX_LPI_TM] = {31'h0, i_rx_lpi & unit_tick};
    if (i_tx_done) begin
      addv[SL_TX_FCS] = {31'h0, i_tx_fcs_err};
      addv[SL_TX_DEFER] = {31'h0, i_tx_defer_err};
      addv[SL_TX_CARR] = {31'h0, i_tx_carrier_err};
      addv[SL_TX_BADB] = tx_any_err ? {18'h0, i_tx_len} : 32'h00000000;
      addv[SL_TX_SCOL] = {31'h0, i_tx_single_col};
      addv[SL_TX_MCOL] = {31'h0, i_tx_multi_col};
      addv[SL_TX_XCOL] = {31'h0, i_tx_exc_col};
      addv[SL_TX_LCOL] = {31'h0, i_tx_late_col};
      if (!tx_any_err) begin
        addv[SL_TX_BYTES + cast_idx(i_tx_cast)] = {18'h0, i_tx_len};
        addv[SL_TX_FRAMES + cast_idx(i_tx_cast)] = 32'h00000001;
        addv[SL_TX_PAUSE] = {31'h0, i_tx_pause};
        addv[SL_TX_BIN + len_bin(i_tx_len)] = 32'h00000001;
      end
    end
    addv[SL_TX_LPI_TR] = {31'h0, i_tx_lpi & !tx_lpi_q_r};
    addv[SL_TX_LPI_TM] = {31'h0, i_tx_lpi & unit_tick};
  end

  // Counter bank; narrow counters wrap at 20 bits and read zero-extended
  for (genvar g = 0; g < NSLOT; g++) begin : g_cnt
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) cnt_r[g] <= 32'h00000000;
      else if (lite_r) cnt_r[g] <= 32'h00000000;
      else cnt_r[g] <= (cnt_r[g] + addv[g]) & slot_mask(g);
    end
    // Slot g lands at byte 4*g of the data stage
    assign snap_flat[g*32 +: 32] = cnt_r[g];
  end

  // Frozen copy so a long data stage never tears across counter updates
  stats_snap_mem u_snap (
    .i_ref_clk   (i_ref_clk),
    .i_load      (setup_hit),
    .i_load_data (snap_flat),
    .i_rd_addr   (idx_r[7:2]),
    .o_rd_data   (rd_word)
  );

  // Request decode; any other request belongs to another handler
  assign setup_hit = i_setup_valid && i_req_type == REQ_TYPE && i_req_code == REQ_CODE
                     && i_req_value == 16'h0000 && i_req_index == 16'h0000;

  // Sender: fetch a word, then hand out its bytes lowest first
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      idx_r <= 8'h00;
      rem_r <= 8'h00;
    end else if (setup_hit) begin
      // New setup restarts even a transfer in progress, as USB does
      idx_r <= 8'h00;
      if (i_req_length > {8'h00, SNAP_BYTES}) rem_r <= SNAP_BYTES;
      else rem_r <= i_req_length[7:0];
      state_r <= (i_req_length == 16'h0000) ? ST_IDLE : ST_FETCH;
    end else begin
      unique case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_FETCH: state_r <= ST_PRESENT;
        ST_PRESENT: state_r <= ST_HOLD;
        ST_HOLD: begin
          if (i_data_ready) begin
            idx_r <= idx_r + 8'h01;
            rem_r <= rem_r - 8'h01;
            if (rem_r == 8'h01) state_r <= ST_IDLE;
            else if (idx_r[1:0] == 2'h3) state_r <= ST_FETCH;
            else state_r <= ST_PRESENT;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Data stage outputs, loaded while presenting a byte
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data <= 8'h00;
      o_data_valid <= 1'b0;
      o_data_last <= 1'b0;
      o_req_ack <= 1'b0;
    end else begin
      o_req_ack <= setup_hit;
      if (setup_hit) begin
        o_data_valid <= 1'b0;
        o_data_last <= 1'b0;
      end else if (state_r == ST_PRESENT) begin
        o_data <= rd_word[idx_r[1:0]*8 +: 8];
        o_data_valid <= 1'b1;
        o_data_last <= (rem_r == 8'h01);
      end else if (state_r == ST_HOLD && i_data_ready) begin
        o_data_valid <= 1'b0;
        o_data_last <= 1'b0;
      end
    end
  end

  // APB: answer one cycle into the access phase, zero wait after that
  assign apb_acc = i_psel && i_penable && !o_pready;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= apb_acc;
      o_pslverr <= apb_acc && !(i_paddr == A_CTRL || i_paddr == A_MAXSZ
                   || i_paddr == A_VLAN || i_paddr == A_STAT);
      o_prdata <= 32'h00000000;
      if (apb_acc && !i_pwrite) begin
        unique case (i_paddr)
          A_CTRL: o_prdata <= {30'h0, store_bad_r, vlan_allow_r};
          A_MAXSZ: o_prdata <= {18'h0, max_size_r};
          A_VLAN: o_prdata <= {16'h0, vlan_ethertype_reg_r};
          A_STAT: o_prdata <= {27'h0, state_r, state_r != ST_IDLE};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes land on the edge that sees pready high
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vlan_allow_r <= 1'b0;
      store_bad_r <= 1'b0;
      lite_r <= 1'b0;
      max_size_r <= MAXSZ_RST;
      vlan_ethertype_reg_r <= VLAN_RST;
    end else begin
      lite_r <= 1'b0;
      if (i_psel && i_penable && o_pready && i_pwrite) begin
        unique case (i_paddr)
          A_CTRL: begin
            vlan_allow_r <= i_pwdata[B_VLAN_ALLOW];
            store_bad_r <= i_pwdata[B_STORE_BAD];
            lite_r <= i_pwdata[B_LITE_RST];
          end
          A_MAXSZ: max_size_r <= i_pwdata[13:0];
          A_VLAN: vlan_ethertype_reg_r <= i_pwdata[15:0];
          default: lite_r <= 1'b0;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  jabber_only_a: assert property (i_rx_done && rx_err && rx_long && !lite_r
    |=> cnt_r[SL_RX_FCS] == $past(cnt_r[SL_RX_FCS])
        && cnt_r[SL_RX_JAB] == (($past(cnt_r[SL_RX_JAB]) + 1) & 32'h000fffff))
    else $error("jabber frame touched fcs counter");
  frag_only_a: assert property (i_rx_done && i_rx_fcs_err && rx_short && !lite_r
    |=> cnt_r[SL_RX_FCS] == $past(cnt_r[SL_RX_FCS])
        && cnt_r[SL_RX_FRAG] == (($past(cnt_r[SL_RX_FRAG]) + 1) & 32'h000fffff))
    else $error("short fcs frame miscounted");
  align_inc_a: assert property (i_rx_done && i_rx_align_err && !lite_r
    |=> cnt_r[SL_RX_ALIGN] == (($past(cnt_r[SL_RX_ALIGN]) + 1) & 32'h000fffff))
    else $error("alignment counter missed");
  under_inc_a: assert property (i_rx_done && rx_short
    && !rx_err && !i_rx_align_err && !lite_r
    |=> cnt_r[SL_RX_UNDER] == (($past(cnt_r[SL_RX_UNDER]) + 1) & 32'h000fffff))
    else $error("undersize counter missed");
  over_len_a: assert property (i_rx_done && !rx_err && !i_rx_align_err && !lite_r
    && i_rx_len == max_len
    |=> cnt_r[SL_RX_OVER] == $past(cnt_r[SL_RX_OVER]))
    else $error("frame at limit counted oversize");
  vlan_limit_a: assert property (vlan_allow_r && tag1 && !tag2
    |-> max_len == max_size_r + TAG_LEN)
    else $error("single tag allowance wrong");
  drop_gate_a: assert property (i_rx_done && i_rx_drop && rx_err && !store_bad_r
    && !lite_r |=> cnt_r[SL_RX_DROP] == $past(cnt_r[SL_RX_DROP]))
    else $error("errored drop counted without storing");
  lite_clear_a: assert property (lite_r |=> cnt_r[SL_RX_FCS] == 32'h0
    && cnt_r[SL_TX_LPI_TM] == 32'h0)
    else $error("lite reset left counters");
  first_byte_a: assert property (setup_hit && i_req_length != 16'h0
    |=> ##2 o_data_valid && o_data_last == (rem_r == 8'h01))
    else $error("first snapshot byte late");
endmodule // ethernet_statistics_counters
`default_nettype wire

/* bench/usb_host_model.sv */
// Host model: sends the statistics setup and gathers the data stage
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
  input  wire logic          i_ref_clk, // Clock
  input  wire logic          i_go,      // Start request
  input  wire logic          i_slow,    // Stall every other cycle
  input  wire logic [7:0]    i_code,    // Request code
  input  wire logic [15:0]   i_len,     // Requested length
  input  wire logic [7:0]    i_data,    // Byte from device
  input  wire logic          i_valid,   // Byte offered
  output logic               o_setup,   // Setup pulse
  output logic      [7:0]    o_code,    // Request code
  output logic      [15:0]   o_len,     // Length
  output logic               o_ready,   // Byte taken
  output logic      [8:0]    o_cnt,     // Bytes gathered
  output logic      [1503:0] o_snap     // Bytes, first lowest
);
  initial {o_setup, o_ready, o_cnt, o_code, o_len} = '0;
  // Stalls check that the device holds each byte until taken
  always @(posedge i_ref_clk) begin
    o_setup <= i_go;
    o_code <= i_code;
    o_len <= i_len;
    o_ready <= i_slow ? ~o_ready : 1'b1;
    if (i_go) o_cnt <= '0;
    else if (i_valid && o_ready) begin
      o_snap[o_cnt*8 +: 8] <= i_data;
      o_cnt <= o_cnt + 9'h001;
    end
  end
endmodule // usb_host_model
`default_nettype wire

/* bench/ethernet_statistics_counters_tb.sv */
// Bench: frames in, counter snapshot out through the host model
`timescale 1ns/1ns
`default_nettype none
module ethernet_statistics_counters_tb;
  import stats_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pw = 0, rxd = 0, txd = 0, rp = 0; // Drivers
  logic rxl = 0, txl = 0, go = 0, slow = 0, rdy, err, ack, dv, dl, stp, hrdy; // Handshakes
  logic [11:0] pa = '0;                 // APB address
  logic [31:0] pwd = '0, prd, rd;       // APB data
  logic [13:0] rlen = '0, tlen = '0;    // Frame lengths
  logic [3:0]  re = '0;                 // Drop, align, sym, fcs
  logic [6:0]  te = '0;                 // Late..fcs status
  logic [1:0]  rc = '0, tc = '0;        // Cast kinds
  logic [15:0] rt = '0, ri = '0, hlen = '0, hl; // Types, lengths
  logic [7:0]  code = REQ_CODE, hc, dat; // Request code, data byte
  logic [8:0]  cnt;                     // Bytes gathered
  logic [1503:0] snap;                  // Gathered snapshot
  logic [31:0] ex [NSLOT];              // Expected slots
  int n_errors = 0, checked = 0, acks = 0, last_at = -1;
  always #10 clk = ~clk;
  always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;
  // Position of the byte flagged last in the latest data stage
  always @(posedge clk) begin
    if (go) last_at <= -1;
    else if (dv === 1'b1 && hrdy === 1'b1 && dl === 1'b1) last_at <= cnt;
  end
  ethernet_statistics_counters dut (.i_ref_clk(clk), .i_nrst(nrst), .i_paddr(pa),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .i_rx_done(rxd), .i_rx_len(rlen), .i_rx_fcs_err(re[0]),
    .i_rx_sym_err(re[1]), .i_rx_align_err(re[2]), .i_rx_drop(re[3]), .i_rx_cast(rc),
    .i_rx_pause(rp), .i_rx_type(rt), .i_rx_inner_type(ri), .i_rx_lpi(rxl), .i_tx_done(txd),
    .i_tx_len(tlen), .i_tx_fcs_err(te[0]), .i_tx_defer_err(te[1]), .i_tx_carrier_err(te[2]),
    .i_tx_single_col(te[3]), .i_tx_multi_col(te[4]), .i_tx_exc_col(te[5]),
    .i_tx_late_col(te[6]), .i_tx_cast(tc), .i_tx_pause(rp), .i_tx_lpi(txl),
    .i_setup_valid(stp), .i_req_type(REQ_TYPE), .i_req_code(hc), .i_req_value(16'h0000),
    .i_req_index(16'h0000), .i_req_length(hl), .o_req_ack(ack), .o_data(dat),
    .o_data_valid(dv), .o_data_last(dl), .i_data_ready(hrdy));
  usb_host_model host (.i_ref_clk(clk), .i_go(go), .i_slow(slow), .i_code(code),
    .i_len(hlen), .i_data(dat), .i_valid(dv), .o_setup(stp), .o_code(hc), .o_len(hl),
    .o_ready(hrdy), .o_cnt(cnt), .o_snap(snap));
  // Verdict and counts, the single exit of the run
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // APB cycle; waits on pready with a bound, samples at that edge only
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pw, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    for (int k = 0; rdy !== 1'b1; k++) begin
      @(posedge clk);
      if (k > 20) begin n_errors++; end_of_test(); end
    end
    rd = err ? 32'hdead0000 : prd;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rx(input logic [13:0] n, input logic [3:0] e, input logic [1:0] c,
                    input logic [15:0] t, input logic [15:0] i);
    @(posedge clk);
    {rxd, rlen, re, rc, rt, ri} <= {1'b1, n, e, c, t, i};
    @(posedge clk);
    rxd <= 1'b0;
  endtask
  task automatic tx(input logic [13:0] n, input logic [6:0] e, input logic [1:0] c);
    @(posedge clk);
    {txd, tlen, te, tc} <= {1'b1, n, e, c};
    @(posedge clk);
    txd <= 1'b0;
  endtask
  // Request n bytes, then compare every whole slot received
  task automatic snap_chk(input logic [15:0] n);
    int a0 = acks;
    {go, hlen} <= {1'b1, n};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int k = 0; cnt != n; k++) begin
      @(posedge clk);
      if (k > 2000) begin n_errors++; end_of_test(); end
    end
    cmp("ack", a0 + 1, acks);
    cmp("last at", n - 16'h0001, last_at);
    for (int k = 0; k < n / 4; k++) cmp($sformatf("slot%0d", k), ex[k], snap[k*32 +: 32]);
  endtask
  // Receive error classes and precedence, store-bad drop
  task automatic s_rx_err;
    rx(14'd100, 4'h1, 0, 0, 0);
    rx(14'd1519, 4'h1, 0, 0, 0);
    rx(14'd63, 4'h2, 0, 0, 0);
    rx(14'd63, 4'h1, 0, 0, 0);
    rx(14'd100, 4'h4, 0, 0, 0);
    rx(14'd63, 4'h0, 0, 0, 0);
    rx(14'd1519, 4'h0, 0, 0, 0);
    rx(14'd1518, 4'h0, 0, 0, 0);
    rx(14'd100, 4'h8, 0, 0, 0);
    rx(14'd100, 4'h9, 0, 0, 0);
    apb(1, A_CTRL, 32'h0000_0002);
    rx(14'd100, 4'h9, 0, 0, 0);
    ex[SL_RX_FCS] = 3;
    ex[SL_RX_ALIGN] = 1;
    ex[SL_RX_FRAG] = 2;
    ex[SL_RX_JAB] = 1;
    ex[SL_RX_UNDER] = 1;
    ex[SL_RX_OVER] = 1;
    ex[SL_RX_DROP] = 2;
    snap_chk(16'd28);
  endtask
  // Another vendor code belongs to another handler: no ack, no bytes
  task automatic s_refuse;
    int a0 = acks;
    {go, code, hlen} <= {1'b1, 8'ha1, 16'h0004};
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
    cmp("refused ack", a0, acks);
    cmp("refused bytes", 0, cnt);
    code <= REQ_CODE;
  endtask
  // Tag allowance with standard and programmed ethertype, stacked tags
  task automatic s_vlan;
    apb(1, A_CTRL, 32'h0000_0001);
    apb(1, A_VLAN, 32'h0000_9100);
    rx(14'd1522, 0, 0, 16'h8100, 0);
    rx(14'd1523, 0, 0, 16'h8100, 0);
    rx(14'd1526, 0, 0, 16'h9100, 16'h8100);
    rx(14'd1527, 0, 0, 16'h9100, 16'h8100);
    ex[SL_RX_OVER] = 3;
    snap_chk(16'd28);
  endtask
  // Lite reset clears all, then good traffic plus one TX FCS error frame, and stalled full read
  task automatic s_good;
    apb(1, A_CTRL, 32'h0000_0004);
    ex = '{default: 0};
    rx(14'd100, 0, 2'h2, 0, 0);
    rp <= 1'b1;
    rx(14'd64, 0, 2'h1, 0, 0);
    tx(14'd64, 7'h08, 2'h1);
    tx(14'd200, 7'h01, 2'h0);
    rp <= 1'b0;
    {rxl, txl} <= 2'b11;
    // One full time unit in idle sees exactly one tick
    repeat (LPI_UNIT_CYC) @(posedge clk);
    {rxl, txl} <= 2'b00;
    ex[SL_RX_BYTES+2] = 100;
    ex[SL_RX_FRAMES+2] = 1;
    ex[SL_RX_BIN+1] = 1;
    ex[SL_RX_BYTES+1] = 64;
    ex[SL_RX_FRAMES+1] = 1;
    ex[SL_RX_BIN] = 1;
    ex[SL_TX_SCOL] = 1;
    ex[SL_TX_BYTES+1] = 64;
    ex[SL_TX_FRAMES+1] = 1;
    ex[SL_TX_BIN] = 1;
    ex[SL_TX_FCS] = 1;
    ex[SL_TX_BADB] = 200;
    ex[SL_RX_LPI_TR] = 1;
    ex[SL_TX_LPI_TR] = 1;
    ex[SL_RX_LPI_TM] = 1;
    ex[SL_TX_LPI_TM] = 1;
    ex[SL_RX_PAUSE] = 1;
    ex[SL_TX_PAUSE] = 1;
    slow <= 1'b1;
    snap_chk(16'(SNAP_BYTES));
  endtask
  initial begin
    ex = '{default: 0};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(0, A_MAXSZ, 0);
    cmp("maxsz", 32'(MAXSZ_RST), rd);
    apb(0, 12'h100, 0);
    cmp("unmapped", 32'hdead0000, rd);
    s_rx_err();
    s_refuse();
    s_vlan();
    s_good();
    end_of_test();
  end
endmodule // ethernet_statistics_counters_tb
`default_nettype wire
